// File: src/srrc_cfg.svh
// Timing counts and register offsets of the stop release and reset sequencer
`ifndef SRRC_CFG_SVH
`define SRRC_CFG_SVH
`define SRRC_CLK_MHZ 50
`define SRRC_RST_DLY_NS 5000
`define SRRC_RST_DLY_CYC ((`SRRC_RST_DLY_NS * `SRRC_CLK_MHZ) / 1000)
`define SRRC_ACC_MIN_NS 86000
`define SRRC_ACC_CYC (((`SRRC_ACC_MIN_NS * `SRRC_CLK_MHZ) + 999) / 1000)
`define SRRC_PROC_MIN_NS 11000
`define SRRC_PROC_CYC (((`SRRC_PROC_MIN_NS * `SRRC_CLK_MHZ) + 999) / 1000)
`define SRRC_OST_DEF 16'h0100
`define SRRC_HSG_INT_NS 4060
`define SRRC_HSG_INT_CYC (((`SRRC_HSG_INT_NS * `SRRC_CLK_MHZ) + 999) / 1000)
`define SRRC_HSG_EXT_CYC 160
`define SRRC_WAIT_VEC_CYC 8
`define SRRC_WAIT_NXT_CYC 2
`define SRRC_RESET_VEC_ADDR 16'h0000
`define SRRC_ADR_CTRL 4'h0
`define SRRC_ADR_STAT 4'h4
`define SRRC_ADR_OST 4'h8
`define SRRC_CTRL_STOP_BIT 0
`define SRRC_CTRL_HSET_BIT 1
`define SRRC_CTRL_EXTCLK_BIT 2
`define SRRC_CTRL_XOSC_BIT 3
`endif

// File: src/srrc_pkg.sv
// Types of the stop release and reset sequencer
package srrc_pkg;
  typedef enum logic [2:0] {
    SRRC_RUN,
    SRRC_STOP,
    SRRC_OSTAB,
    SRRC_HSGATE,
    SRRC_WAIT,
    SRRC_RESET,
    SRRC_ACCWAIT,
    SRRC_PROC
  } srrc_state_t;
  typedef struct packed {
    logic mask;
    logic prio;
    logic gie;
    logic svc_prio;
  } srrc_irq_t;
  typedef struct packed {
    logic rst_pin_n;
    logic wdt_ovf;
    logic pclr_det;
    logic lowv_det;
  } srrc_rsrc_t;
endpackage

// File: src/srrc_top.sv
// Stop release and system reset sequencer with Wishbone control registers
// Overview of operation
// - Unmasked request ends STOP, vectors or continues
// - Resume wait 8 vectored, 2 otherwise
// - Mask holds STOP; priority and enable decide service
// - Reset during STOP ends it, reset vector follows
// - Four reset sources, identical effect except low-voltage detector reset
// - Start address fetched from vector 0000H/0001H
// - Pins Hi-Z, indicator low, during reset/stabilization
// - Watchdog reset self-releases; pin reset on high
// - Oscillators stopped, external clocks ignored in reset
// - STOP contents kept while reset applied
// - Low-voltage reset spares the low-voltage detector except for one cycle as RESET ends
// - Watchdog reset also resets watchdog timer
// - Accuracy wait then processing before running
// - Internal reset follows pin edges after 5 us
// - Crystal stays stopped until software starts it
// - CPU clock gated, peripherals stopped in reset
// - High-speed setting gates CPU clock after release
`timescale 1ns/1ns
`include "srrc_cfg.svh"
module srrc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire srrc_pkg::srrc_rsrc_t rsrc_i,
  input wire logic irq_req_i,
  input wire srrc_pkg::srrc_irq_t irq_i,
  output logic cpu_clk_en_o,
  output logic periph_rst_o,
  output logic wdt_rst_o,
  output logic lowv_rst_o,
  output logic osc_en_o,
  output logic xosc_en_o,
  output logic ext_clk_valid_o,
  output logic vector_fetch_o,
  output logic [15:0] vector_addr_o,
  output logic irq_service_o,
  output logic pins_hiz_o,
  output logic reset_indicator_pin_o,
  output logic reset_indicator_pin_oe_n_o,
  output logic stop_held_o
);
  // Two flip-flop synchronisers for the reset sources and the wake request
  // sync async inputs
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 5'h01;
      sync2_ff <= 5'h01;
    end
    else
    begin
      sync1_ff <= {irq_req_i, rsrc_i.lowv_det, rsrc_i.pclr_det, rsrc_i.wdt_ovf, rsrc_i.rst_pin_n};
      sync2_ff <= sync1_ff;
    end
  end
  wire pin_n_s = sync2_ff[0];
  wire wdt_s = sync2_ff[1];
  wire pclr_s = sync2_ff[2];
  wire lowv_s = sync2_ff[3];
  wire wake_s = sync2_ff[4];

  logic pin_filt_ff;
  logic [15:0] dly_cnt_ff;
  wire [15:0] dly_max = 16'(`SRRC_RST_DLY_CYC);
  wire pin_diff = pin_n_s != pin_filt_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_filt_ff <= 1'b1;
      dly_cnt_ff <= 16'h0000;
    end
    else if (!pin_diff)
      dly_cnt_ff <= 16'h0000;
    else if (dly_cnt_ff == dly_max - 16'h0001)
    begin
      pin_filt_ff <= pin_n_s;
      dly_cnt_ff <= 16'h0000;
    end
    else
      dly_cnt_ff <= dly_cnt_ff + 16'h0001;
  end

  // short pin pulses may be lost by the delay filter
  wire rst_any = !pin_filt_ff || wdt_s || pclr_s || lowv_s;

  // Registers
  logic stop_req_ff;
  logic hset_ff;
  logic extclk_ff;
  logic xosc_ff;
  logic [15:0] ost_ff;
  logic [1:0] cause_ff;
  logic ack_ff;
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wb_wr = wb_req && wb_we_i;
  wire sel_ctrl = wb_adr_i == `SRRC_ADR_CTRL;
  wire sel_stat = wb_adr_i == `SRRC_ADR_STAT;
  wire sel_ost = wb_adr_i == `SRRC_ADR_OST;

  srrc_pkg::srrc_state_t state_ff;
  srrc_pkg::srrc_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic vec_ff;
  logic nxt_vec;

  function automatic logic srrc_service(input srrc_pkg::srrc_irq_t q);
    srrc_service = q.prio ? (q.gie && q.svc_prio) : q.gie;
  endfunction

  wire wake = wake_s && !irq_i.mask;
  wire [15:0] hsg_cyc = extclk_ff ? 16'(`SRRC_HSG_EXT_CYC) : 16'(`SRRC_HSG_INT_CYC);
  wire [15:0] wait_cyc = vec_ff ? 16'(`SRRC_WAIT_VEC_CYC) : 16'(`SRRC_WAIT_NXT_CYC);
  wire cnt_done = cnt_ff == 16'h0000;
  wire stop_cmd = wb_wr && sel_ctrl && wb_sel_i[0] && wb_dat_i[`SRRC_CTRL_STOP_BIT];

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_done ? 16'h0000 : cnt_ff - 16'h0001;
    nxt_vec = vec_ff;
    if (rst_any)
    begin
      nxt_state = srrc_pkg::SRRC_RESET;
      nxt_cnt = 16'h0000;
    end
    else
    begin
      case (state_ff)
        srrc_pkg::SRRC_RUN:
          if (stop_cmd)
            nxt_state = srrc_pkg::SRRC_STOP;
        srrc_pkg::SRRC_STOP:
          if (wake)
          begin
            nxt_state = srrc_pkg::SRRC_OSTAB;
            nxt_cnt = ost_ff;
            nxt_vec = srrc_service(irq_i);
          end
        srrc_pkg::SRRC_OSTAB:
          if (cnt_done)
          begin
            nxt_state = hset_ff ? srrc_pkg::SRRC_HSGATE : srrc_pkg::SRRC_WAIT;
            nxt_cnt = hset_ff ? hsg_cyc : wait_cyc;
          end
        srrc_pkg::SRRC_HSGATE:
          if (cnt_done)
          begin
            nxt_state = srrc_pkg::SRRC_WAIT;
            nxt_cnt = wait_cyc;
          end
        srrc_pkg::SRRC_WAIT:
          if (cnt_done)
            nxt_state = srrc_pkg::SRRC_RUN;
        srrc_pkg::SRRC_RESET:
        begin
          nxt_state = srrc_pkg::SRRC_ACCWAIT;
          nxt_cnt = 16'(`SRRC_ACC_CYC);
        end
        srrc_pkg::SRRC_ACCWAIT:
          if (cnt_done)
          begin
            nxt_state = srrc_pkg::SRRC_PROC;
            nxt_cnt = 16'(`SRRC_PROC_CYC);
          end
        srrc_pkg::SRRC_PROC:
          if (cnt_done)
            nxt_state = srrc_pkg::SRRC_RUN;
        default:
          nxt_state = srrc_pkg::SRRC_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= srrc_pkg::SRRC_RESET;
      cnt_ff <= 16'h0000;
      vec_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      vec_ff <= nxt_vec;
    end
  end

  wire in_rst = state_ff == srrc_pkg::SRRC_RESET;
  wire in_acc = state_ff == srrc_pkg::SRRC_ACCWAIT;
  wire in_proc = state_ff == srrc_pkg::SRRC_PROC;
  wire in_stop = state_ff == srrc_pkg::SRRC_STOP;
  wire leave_wait = state_ff == srrc_pkg::SRRC_WAIT && cnt_done && !rst_any;
  wire leave_proc = in_proc && cnt_done && !rst_any;

  // Settings other than crystal start ride through source resets, so STOP setup survives
  // settings kept in reset, crystal start cleared
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hset_ff <= 1'b0;
      extclk_ff <= 1'b0;
      xosc_ff <= 1'b0;
      ost_ff <= `SRRC_OST_DEF;
      cause_ff <= 2'h0;
    end
    else
    begin
      if (in_rst)
        xosc_ff <= 1'b0;
      else if (wb_wr && sel_ctrl && wb_sel_i[0])
      begin
        hset_ff <= wb_dat_i[`SRRC_CTRL_HSET_BIT];
        extclk_ff <= wb_dat_i[`SRRC_CTRL_EXTCLK_BIT];
        xosc_ff <= wb_dat_i[`SRRC_CTRL_XOSC_BIT];
      end
      if (wb_wr && sel_ost)
      begin
        if (wb_sel_i[0])
          ost_ff[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          ost_ff[15:8] <= wb_dat_i[15:8];
      end
      if (rst_any)
        cause_ff <= !pin_filt_ff ? 2'h0 : (wdt_s ? 2'h1 : (pclr_s ? 2'h2 : 2'h3));
    end
  end

  // Bus slave: one wait state, unmapped reads return zero
  logic [31:0] rd_data;
  assign rd_data = sel_ctrl ? {28'h0000000, xosc_ff, extclk_ff, hset_ff, in_stop} :
                   sel_stat ? {25'h0000000, vec_ff, cause_ff, 1'b0, state_ff} :
                   sel_ost ? {16'h0000, ost_ff} : 32'h00000000;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      ack_ff <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_ff;

  // Registered system outputs
  wire rst_phase = in_rst || in_acc || rst_any;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_clk_en_o <= 1'b0;
      periph_rst_o <= 1'b1;
      wdt_rst_o <= 1'b1;
      lowv_rst_o <= 1'b1;
      osc_en_o <= 1'b0;
      xosc_en_o <= 1'b0;
      ext_clk_valid_o <= 1'b0;
      vector_fetch_o <= 1'b0;
      vector_addr_o <= 16'h0000;
      irq_service_o <= 1'b0;
      pins_hiz_o <= 1'b1;
      stop_held_o <= 1'b0;
    end
    else
    begin
      cpu_clk_en_o <= nxt_state == srrc_pkg::SRRC_RUN;
      periph_rst_o <= rst_phase || in_proc;
      wdt_rst_o <= rst_phase || in_proc;
      // detector kept out of its own reset except for one cycle as RESET ends
      lowv_rst_o <= (rst_phase || in_proc) && !lowv_s && !(cause_ff == 2'h3 && !in_rst);
      osc_en_o <= !in_rst && !rst_any && !in_stop;
      xosc_en_o <= xosc_ff && !in_rst && !rst_any && !in_stop;
      ext_clk_valid_o <= !in_rst && !rst_any;
      vector_fetch_o <= leave_proc;
      vector_addr_o <= `SRRC_RESET_VEC_ADDR;
      irq_service_o <= leave_wait && vec_ff;
      pins_hiz_o <= rst_phase;
      stop_held_o <= in_stop;
    end
  end
  assign reset_indicator_pin_o = 1'b0;
  assign reset_indicator_pin_oe_n_o = !pins_hiz_o;

  // Assertions
  chk_wait_vector_len: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == srrc_pkg::SRRC_WAIT) && vec_ff && !rst_any)
    |-> cnt_ff == 16'h0008)
    else $error("vectored wait count wrong");
  chk_wait_next_len: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == srrc_pkg::SRRC_WAIT) && !vec_ff) |-> cnt_ff == 16'h0002)
    else $error("non-vectored wait count wrong");
  chk_masked_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_stop && irq_i.mask && !rst_any) |=> in_stop)
    else $error("masked request left stop");
  chk_wake_leaves_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_stop && wake && !rst_any) |=> state_ff == srrc_pkg::SRRC_OSTAB)
    else $error("unmasked wake ignored");
  chk_reset_enters: assert property (@(posedge clk_i) disable iff (rst_i)
    rst_any |=> in_rst)
    else $error("reset source not acted on");
  chk_cpu_clk_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    in_rst |=> !cpu_clk_en_o)
    else $error("cpu clock running in reset");
  chk_pins_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_rst || in_acc) |=> pins_hiz_o && !reset_indicator_pin_oe_n_o)
    else $error("pins not hi-z in reset");
  chk_osc_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    in_rst |=> !osc_en_o && !ext_clk_valid_o)
    else $error("oscillator running in reset");
  chk_vector_after: assert property (@(posedge clk_i) disable iff (rst_i)
    leave_proc |=> vector_fetch_o && vector_addr_o == 16'h0000 ##1 !vector_fetch_o)
    else $error("reset vector fetch missing");
  chk_xosc_off: assert property (@(posedge clk_i) disable iff (rst_i)
    in_rst |=> !xosc_en_o)
    else $error("crystal running after reset");
endmodule

// File: verif/srrc_far.sv
// Far side model: reset sources and wake requester
`timescale 1ns/1ns
module srrc_far (
  input wire logic clk_i,
  output srrc_pkg::srrc_rsrc_t rsrc_o,
  output logic irq_req_o,
  output srrc_pkg::srrc_irq_t irq_o
);
  initial
  begin
    rsrc_o = 4'h8;
    irq_req_o = 1'b0;
    irq_o = 4'h0;
  end
  task automatic pin_low(input int n);
    @(posedge clk_i);
    rsrc_o.rst_pin_n <= 1'b0;
    repeat (n) @(posedge clk_i);
    rsrc_o.rst_pin_n <= 1'b1;
  endtask
  task automatic pulse(input logic [3:0] s);
    @(posedge clk_i);
    rsrc_o <= s;
    repeat (4) @(posedge clk_i);
    rsrc_o <= 4'h8;
  endtask
  // Request drops again; qualifiers stay put
  task automatic wake(input srrc_pkg::srrc_irq_t v);
    @(posedge clk_i);
    irq_o <= v;
    irq_req_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    irq_req_o <= 1'b0;
  endtask
endmodule

// File: verif/tb.sv
// Self-checking bench of the stop release and reset sequencer
`timescale 1ns/1ns
`include "srrc_cfg.svh"
module tb;
  logic clk_i, rst_i, we, cyc, ack, req, clk_en, prst, wrst, lrst;
  logic osc, xosc, extv, vf, svc, hiz, ind, ind_oe_n, held, s;
  logic [3:0] adr;
  logic [31:0] wdat, dout, rdat;
  logic [15:0] vaddr;
  srrc_pkg::srrc_rsrc_t rsrc;
  srrc_pkg::srrc_irq_t irq;
  int err_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int n, nv, nn;
  logic [3:0] cs [5] = '{4'h2, 4'h0, 4'h7, 4'h6, 4'h5};
  logic [3:0] src [3] = '{4'hc, 4'ha, 4'h9};
  srrc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(dout), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .rsrc_i(rsrc), .irq_req_i(req), .irq_i(irq),
    .cpu_clk_en_o(clk_en), .periph_rst_o(prst), .wdt_rst_o(wrst), .lowv_rst_o(lrst),
    .osc_en_o(osc), .xosc_en_o(xosc), .ext_clk_valid_o(extv), .vector_fetch_o(vf),
    .vector_addr_o(vaddr), .irq_service_o(svc), .pins_hiz_o(hiz),
    .reset_indicator_pin_o(ind), .reset_indicator_pin_oe_n_o(ind_oe_n),
    .stop_held_o(held));
  srrc_far u_far (.clk_i(clk_i), .rsrc_o(rsrc), .irq_req_o(req), .irq_o(irq));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Hang guard well above six boots
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ack and read data are taken at the rising edge; the hang guard ends a lost answer
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    chk("wb ack", 1'b1, ack);
    rdat = dout;
    cyc <= 1'b0;
  endtask
  task automatic boot(output int k);
    k = 0;
    while (vf !== 1'b1 && k < 6000)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("vector fetch", 1'b1, vf);
    chk("vector addr", 16'h0000, vaddr);
  endtask
  task automatic in_rst();
    chk("pins hiz", 1'b1, hiz);
    chk("indicator oe", 1'b0, ind_oe_n);
    chk("indicator", 1'b0, ind);
    chk("cpu clk", 1'b0, clk_en);
    chk("periph rst", 1'b1, prst);
  endtask
  // Always steps to a falling edge, so outputs are never read at their launch edge
  task automatic wait_hiz(output int k);
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (hiz !== 1'b1 && k < 400);
  endtask
  task automatic stop_run(input logic [31:0] c, input srrc_pkg::srrc_irq_t v);
    wb(`SRRC_ADR_CTRL, 1'b1, c);
    @(negedge clk_i);
    chk("stop entered", 1'b1, held);
    u_far.wake(v);
    n = 0;
    s = 1'b0;
    while (clk_en !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      s |= svc;
      n++;
    end
    @(negedge clk_i);
    s |= svc;
    chk("resumed", 1'b1, clk_en);
  endtask
  initial
  begin
    rst_i = 1'b1;
    adr = 4'h0;
    we = 1'b0;
    wdat = 32'h0;
    cyc = 1'b0;
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    in_rst();
    chk("osc off", 1'b0, osc);
    chk("ext clk", 1'b0, extv);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2000) @(negedge clk_i);
    chk("hiz in stab", 1'b1, hiz);
    boot(n);
    chk("boot time", 1'b1, n + 2000 >= 4850 && n + 2000 < 4900);
    chk("crystal", 1'b0, xosc);
    wb(`SRRC_ADR_OST, 1'b0, 32'h0);
    chk("ost reset", 32'h100, rdat);
    wb(4'hc, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rdat);
    $display("test boot done");
    // Short stabilization keeps wake runs brief
    wb(`SRRC_ADR_OST, 1'b1, 32'h4);
    for (int i = 0; i < 5; i++)
    begin
      stop_run(32'h1, cs[i]);
      chk("serviced", cs[i] == 4'h2 || cs[i] == 4'h7, s);
      if (i == 0)
        nv = n;
      if (i == 1)
        nn = n;
    end
    chk("wait diff", 1'b1, nv - nn >= 5 && nv - nn <= 7);
    stop_run(32'h3, 4'h0);
    chk("hs gate int", 1'b1, n - nn >= `SRRC_HSG_INT_CYC);
    stop_run(32'h7, 4'h0);
    chk("hs gate ext", 1'b1, n - nn >= `SRRC_HSG_EXT_CYC);
    $display("test wake done");
    // Crystal start rides along, so the reset below must clear it
    wb(`SRRC_ADR_CTRL, 1'b1, 32'h9);
    u_far.wake(4'ha);
    repeat (50) @(negedge clk_i);
    chk("masked held", 1'b1, held);
    fork
      u_far.pin_low(600);
    join_none
    wait_hiz(n);
    chk("pin delay", 1'b1, n >= 250 && n < 270);
    in_rst();
    wb(`SRRC_ADR_OST, 1'b0, 32'h0);
    chk("ost kept", 32'h4, rdat);
    boot(n);
    chk("run after pin", 1'b1, clk_en);
    chk("crystal after", 1'b0, xosc);
    $display("test stop reset done");
    for (int i = 0; i < 3; i++)
    begin
      u_far.pulse(src[i]);
      wait_hiz(n);
      in_rst();
      chk("wdt rst", 1'b1, wrst);
      chk("lowv rst", src[i] != 4'h9, lrst);
      boot(n);
      chk("self release", 1'b1, clk_en);
      wb(`SRRC_ADR_STAT, 1'b0, 32'h0);
      chk("cause", (i + 1) * 16, rdat);
    end
    $display("test sources done");
    close_out();
  end
endmodule
